// [gfr_gesture_fifo_readout.sv]
// gesture dataset buffer with serial register target and interrupt clears
// Behaviour
// [RL1] full buffer plus new dataset sets overflow status bit 1, dataset dropped
// [RL2] valid status bit 0 sets when level exceeds fill threshold
// [RL3] valid bit clears when gesture inactive and level is zero
// [RL4] interrupt still high after reading level datasets means new data arrived
// [RL5] interrupt clears use write of register address only, no data byte
// [RL6] address access to 0xe4 forces the interrupt output active
// [RL7] address access to 0xe5 clears pending proximity interrupt
// [RL8] address access to 0xe6 clears pending light interrupt
// [RL9] address access to 0xe7 clears all pending non-gesture interrupts
// [RL10] buffer holds 32 datasets of four bytes: up, down, left, right
// [RL11] when full, keep stored datasets and drop the new one
// [RL12] reads of 0xfc..0xff return up, down, left, right of oldest dataset
// [RL13] single-byte reads and multi-byte page reads both supported
// [RL14] read pointer and level advance only when 0xff byte is read
// [RL15] buffer reads while level is zero return zero
// [RL16] gesture interrupt raised while level exceeds fill threshold
// [RL17] host reads level, then page-reads four times that many bytes
// [RL18] page read wraps from 0xff back to 0xfc
// [RL19] buffer clear empties buffer, clears interrupt, valid, overflow, level
// [RL20] level count is an 8-bit register, one count per dataset
// [RL21] gesture interrupt enable unmasks gesture interrupts onto the output
`timescale 1ns/1ps
module gfr_gesture_fifo_readout
  import gfr_pkg::*;
#(
  parameter logic [6:0] BUS_ADDR = GFR_DEF_BUS_ADDR
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  // serial bus pins, open drain
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // interrupt pin, open drain, enable pulls it low
  output logic irq_oe_o,
  // dataset source
  input wire logic ds_valid_i,
  input wire logic [GFR_DS_W-1:0] ds_data_i,
  output logic ds_ready_o,
  // configuration from neighbouring registers
  input wire logic [GFR_LVL_W-1:0] fill_threshold_i,
  input wire logic gesture_active_i,
  input wire logic gesture_irq_enable_i,
  input wire logic buffer_clear_bit_i,
  // other engines' interrupt events
  input wire logic prox_irq_set_i,
  input wire logic light_irq_set_i,
  output logic prox_irq_pending_o,
  output logic light_irq_pending_o,
  output logic gesture_interrupt_o,
  output logic [GFR_LVL_W-1:0] dataset_level_count_o
);
  logic scl_s1_q, scl_s2_q, scl_s3_q;
  logic sda_s1_q, sda_s2_q, sda_s3_q;
  logic scl_rise, scl_fall, bus_start, bus_stop;
  gfr_state_t state_q;
  logic [3:0] cnt_q;
  logic [7:0] shift_q;
  logic [7:0] tx_q;
  logic [7:0] ptr_q;
  logic rw_q;
  logic nack_q;
  logic [GFR_DS_W-1:0] mem_q [GFR_DEPTH];
  logic [GFR_PTR_W-1:0] wr_ptr_q;
  logic [GFR_PTR_W-1:0] rd_ptr_q;
  logic [GFR_LVL_W-1:0] level_q;
  logic overflow_q;
  logic valid_q;
  logic force_q, prox_q, light_q;
  logic buf_valid;
  logic [GFR_DS_W-1:0] buf_data;
  logic buf_ready;
  logic push, pop, full;
  logic load_en;
  logic [7:0] load_ptr;
  logic reg_done;
  logic gest_irq;
  logic [7:0] status_byte;

  // next register address during a streamed read
  function automatic logic [7:0] next_ptr(input logic [7:0] p);
    if (p == GFR_RIGHT_ADDR) begin
      next_ptr = GFR_UP_ADDR; // RL18
    end else begin
      next_ptr = p + 8'h01;
    end
  endfunction

  // byte returned for a register address
  function automatic logic [7:0] read_byte(input logic [7:0] p,
                                           input logic [GFR_DS_W-1:0] ds,
                                           input logic empty,
                                           input logic [7:0] stat,
                                           input logic [7:0] lvl);
    read_byte = GFR_BYTE_ZERO;
    case (p)
      GFR_UP_ADDR: read_byte = empty ? GFR_BYTE_ZERO : ds[GFR_UP_LSB +: 8]; // RL12 RL15
      GFR_DOWN_ADDR: read_byte = empty ? GFR_BYTE_ZERO : ds[GFR_DOWN_LSB +: 8];
      GFR_LEFT_ADDR: read_byte = empty ? GFR_BYTE_ZERO : ds[GFR_LEFT_LSB +: 8];
      GFR_RIGHT_ADDR: read_byte = empty ? GFR_BYTE_ZERO : ds[GFR_RIGHT_LSB +: 8];
      GFR_STATUS_ADDR: read_byte = stat;
      GFR_LEVEL_ADDR: read_byte = lvl; // RL20
      default: read_byte = GFR_BYTE_ZERO;
    endcase
  endfunction

  // pin synchronisers; stage one feeds only stage two
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      scl_s1_q <= 1'b1;
      scl_s2_q <= 1'b1;
      scl_s3_q <= 1'b1;
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
      sda_s3_q <= 1'b1;
    end else begin
      scl_s1_q <= scl_i;
      scl_s2_q <= scl_s1_q;
      scl_s3_q <= scl_s2_q;
      sda_s1_q <= sda_i;
      sda_s2_q <= sda_s1_q;
      sda_s3_q <= sda_s2_q;
    end
  end

  // edge and frame condition detection on the synchronised pins
  assign scl_rise = scl_s2_q & ~scl_s3_q;
  assign scl_fall = ~scl_s2_q & scl_s3_q;
  assign bus_start = scl_s2_q & scl_s3_q & sda_s3_q & ~sda_s2_q;
  assign bus_stop = scl_s2_q & scl_s3_q & ~sda_s3_q & sda_s2_q;

  // register byte completes on the falling edge after its eighth bit
  assign reg_done = scl_fall && (state_q == GFR_ST_REG) && (cnt_q == GFR_BITS_PER_BYTE);

  // load of a transmit byte, at the start of each read byte
  assign load_en = scl_fall &&
                   (((state_q == GFR_ST_ACK_ADDR) && rw_q) ||
                    ((state_q == GFR_ST_MACK) && !nack_q)); // RL13
  assign load_ptr = (state_q == GFR_ST_ACK_ADDR) ? ptr_q : next_ptr(ptr_q);

  // bus protocol sequencer
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_q <= GFR_ST_IDLE;
      cnt_q <= GFR_CNT_ZERO;
      shift_q <= GFR_BYTE_ZERO;
      rw_q <= 1'b0;
      nack_q <= 1'b0;
    end else if (bus_start) begin
      state_q <= GFR_ST_ADDR; // repeated start allowed anywhere
      cnt_q <= GFR_CNT_ZERO;
    end else if (bus_stop) begin
      state_q <= GFR_ST_IDLE;
    end else begin
      case (state_q)
        GFR_ST_IDLE: begin
          cnt_q <= GFR_CNT_ZERO;
        end
        GFR_ST_ADDR, GFR_ST_REG, GFR_ST_WDATA: begin
          if (scl_rise) begin
            shift_q <= {shift_q[6:0], sda_s2_q};
            cnt_q <= cnt_q + GFR_CNT_ONE;
          end else if (scl_fall && cnt_q == GFR_BITS_PER_BYTE) begin
            cnt_q <= GFR_CNT_ZERO;
            if (state_q == GFR_ST_ADDR) begin
              if (shift_q[7:1] == BUS_ADDR) begin
                rw_q <= shift_q[0];
                state_q <= GFR_ST_ACK_ADDR;
              end else begin
                state_q <= GFR_ST_IDLE; // not ours, wait for next start
              end
            end else begin
              state_q <= GFR_ST_ACK_REG;
            end
          end
        end
        GFR_ST_ACK_ADDR: begin
          if (scl_fall) begin
            state_q <= rw_q ? GFR_ST_TX : GFR_ST_REG;
          end
        end
        GFR_ST_ACK_REG: begin
          if (scl_fall) begin
            state_q <= GFR_ST_WDATA; // data bytes are acked and ignored here
          end
        end
        GFR_ST_TX: begin
          if (scl_rise) begin
            cnt_q <= cnt_q + GFR_CNT_ONE;
          end else if (scl_fall && cnt_q == GFR_BITS_PER_BYTE) begin
            cnt_q <= GFR_CNT_ZERO;
            state_q <= GFR_ST_MACK;
          end
        end
        GFR_ST_MACK: begin
          if (scl_rise) begin
            nack_q <= sda_s2_q;
          end else if (scl_fall) begin
            state_q <= nack_q ? GFR_ST_IDLE : GFR_ST_TX;
          end
        end
        default: begin
          state_q <= GFR_ST_IDLE;
        end
      endcase
    end
  end

  // register pointer: set by the register byte, stepped per read byte
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ptr_q <= GFR_BYTE_ZERO;
    end else if (reg_done) begin
      ptr_q <= shift_q;
    end else if (load_en && state_q == GFR_ST_MACK) begin
      ptr_q <= load_ptr; // RL18
    end
  end

  // transmit shifter; data goes out msb first after scl falls
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      tx_q <= GFR_BYTE_ZERO;
    end else if (load_en) begin
      tx_q <= read_byte(load_ptr, mem_q[rd_ptr_q], level_q == GFR_LVL_ZERO,
                        status_byte, level_q); // RL12
    end else if (scl_fall && state_q == GFR_ST_TX && cnt_q != GFR_BITS_PER_BYTE) begin
      tx_q <= {tx_q[6:0], 1'b0};
    end
  end

  // open-drain data drive: acks and zero bits pull the line low
  assign sda_o = 1'b0;
  assign sda_oe_o = (state_q == GFR_ST_ACK_ADDR) ||
                    (state_q == GFR_ST_ACK_REG) ||
                    ((state_q == GFR_ST_TX) && !tx_q[7]);

  // dataset input buffer; stalls while a clear is applied
  assign buf_ready = ~buffer_clear_bit_i;

  gfr_skid2 #(
    .WIDTH(GFR_DS_W)
  ) u_skid (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .in_valid_i(ds_valid_i),
    .in_data_i(ds_data_i),
    .in_ready_o(ds_ready_o),
    .out_valid_o(buf_valid),
    .out_data_o(buf_data),
    .out_ready_i(buf_ready)
  );

  assign full = (level_q == GFR_LVL_FULL);
  assign push = buf_valid & buf_ready & ~full; // RL11
  // popping on the right-lane load keeps partial page reads from losing data
  assign pop = load_en && (load_ptr == GFR_RIGHT_ADDR) && (level_q != GFR_LVL_ZERO); // RL14

  // dataset storage, 32 words of four lanes
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wr_ptr_q] <= buf_data; // RL10
    end
  end

  // pointers and level; clear takes precedence, input is stalled then
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      level_q <= GFR_LVL_ZERO;
    end else if (buffer_clear_bit_i) begin
      wr_ptr_q <= '0; // RL19
      rd_ptr_q <= '0;
      level_q <= GFR_LVL_ZERO;
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + GFR_PTR_ONE;
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + GFR_PTR_ONE; // RL14
      end
      if (push && !pop) begin
        level_q <= level_q + GFR_LVL_ONE; // RL20
      end else if (pop && !push) begin
        level_q <= level_q - GFR_LVL_ONE;
      end
    end
  end

  // overflow flag: sticky until a buffer clear
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      overflow_q <= 1'b0;
    end else if (buffer_clear_bit_i) begin
      overflow_q <= 1'b0; // RL19
    end else if (buf_valid && buf_ready && full) begin
      overflow_q <= 1'b1; // RL1
    end
  end

  // valid-data flag
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      valid_q <= 1'b0;
    end else if (level_q > fill_threshold_i && !buffer_clear_bit_i) begin
      valid_q <= 1'b1; // RL2
    end else if (buffer_clear_bit_i) begin
      valid_q <= 1'b0; // RL19
    end else if (!gesture_active_i && level_q == GFR_LVL_ZERO) begin
      valid_q <= 1'b0; // RL3
    end
  end

  // gesture interrupt follows the level, so it stays up if data arrived mid-read
  assign gest_irq = (level_q > fill_threshold_i); // RL16 RL4

  // status byte from its named field positions; the unused upper bits read zero
  always_comb begin
    status_byte = GFR_BYTE_ZERO;
    status_byte[GFR_OVERFLOW_BIT] = overflow_q; // RL1
    status_byte[GFR_VALID_BIT] = valid_q; // RL2
  end

  // other pending interrupts; a set in the clearing cycle wins
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      force_q <= 1'b0;
      prox_q <= 1'b0;
      light_q <= 1'b0;
    end else begin
      if (reg_done && shift_q == GFR_FORCE_ADDR) begin
        force_q <= 1'b1; // RL6 RL5
      end else if (reg_done && shift_q == GFR_NONGEST_CLR_ADDR) begin
        force_q <= 1'b0; // RL9
      end
      if (prox_irq_set_i) begin
        prox_q <= 1'b1;
      end else if (reg_done && (shift_q == GFR_PROX_CLR_ADDR ||
                                shift_q == GFR_NONGEST_CLR_ADDR)) begin
        prox_q <= 1'b0; // RL7 RL9
      end
      if (light_irq_set_i) begin
        light_q <= 1'b1;
      end else if (reg_done && (shift_q == GFR_LIGHT_CLR_ADDR ||
                                shift_q == GFR_NONGEST_CLR_ADDR)) begin
        light_q <= 1'b0; // RL8 RL9
      end
    end
  end

  // interrupt pin; the gesture source is gated by its enable
  assign irq_oe_o = force_q | prox_q | light_q | (gest_irq & gesture_irq_enable_i); // RL21
  assign prox_irq_pending_o = prox_q;
  assign light_irq_pending_o = light_q;
  assign gesture_interrupt_o = gest_irq;
  assign dataset_level_count_o = level_q;
endmodule // gfr_gesture_fifo_readout

// [gfr_pkg.sv]
// shared constants for the gesture buffer readout block
package gfr_pkg;
  // register byte addresses
  localparam logic [7:0] GFR_LEVEL_ADDR = 8'hae;
  localparam logic [7:0] GFR_STATUS_ADDR = 8'haf;
  localparam logic [7:0] GFR_FORCE_ADDR = 8'he4;
  localparam logic [7:0] GFR_PROX_CLR_ADDR = 8'he5;
  localparam logic [7:0] GFR_LIGHT_CLR_ADDR = 8'he6;
  localparam logic [7:0] GFR_NONGEST_CLR_ADDR = 8'he7;
  localparam logic [7:0] GFR_UP_ADDR = 8'hfc;
  localparam logic [7:0] GFR_DOWN_ADDR = 8'hfd;
  localparam logic [7:0] GFR_LEFT_ADDR = 8'hfe;
  localparam logic [7:0] GFR_RIGHT_ADDR = 8'hff;
  // status field positions
  localparam int GFR_VALID_BIT = 0;
  localparam int GFR_OVERFLOW_BIT = 1;
  // buffer geometry
  localparam int GFR_DEPTH = 32;
  localparam int GFR_PTR_W = 5;
  localparam int GFR_LVL_W = 8;
  localparam int GFR_DS_W = 32;
  localparam logic [GFR_LVL_W-1:0] GFR_LVL_FULL = 8'h20;
  localparam logic [GFR_LVL_W-1:0] GFR_LVL_ZERO = 8'h00;
  localparam logic [GFR_PTR_W-1:0] GFR_PTR_ONE = 5'h01;
  localparam logic [GFR_LVL_W-1:0] GFR_LVL_ONE = 8'h01;
  // byte lanes of a dataset word
  localparam int GFR_UP_LSB = 0;
  localparam int GFR_DOWN_LSB = 8;
  localparam int GFR_LEFT_LSB = 16;
  localparam int GFR_RIGHT_LSB = 24;
  // serial byte framing
  localparam logic [3:0] GFR_BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] GFR_CNT_ONE = 4'h1;
  localparam logic [3:0] GFR_CNT_ZERO = 4'h0;
  localparam logic [7:0] GFR_BYTE_ZERO = 8'h00;
  // target address, arbitrary value
  localparam logic [6:0] GFR_DEF_BUS_ADDR = 7'h2a;
  typedef enum logic [2:0] {
    GFR_ST_IDLE,
    GFR_ST_ADDR,
    GFR_ST_ACK_ADDR,
    GFR_ST_REG,
    GFR_ST_ACK_REG,
    GFR_ST_WDATA,
    GFR_ST_TX,
    GFR_ST_MACK
  } gfr_state_t;
endpackage

// [gfr_skid2.sv]
// two-entry valid/ready buffer in front of the dataset store
`timescale 1ns/1ps
module gfr_skid2 #(
  parameter int WIDTH = 32
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);
  logic [WIDTH-1:0] mem_q [2];
  logic wr_q;
  logic rd_q;
  logic [1:0] cnt_q;
  logic push;
  logic pop;

  assign in_ready_o = (cnt_q != 2'h2);
  assign out_valid_o = (cnt_q != 2'h0);
  assign out_data_o = mem_q[rd_q];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  // storage; entries need no reset, occupancy guards them
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end

  // pointers and occupancy
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      if (push) begin
        wr_q <= ~wr_q;
      end
      if (pop) begin
        rd_q <= ~rd_q;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 2'h1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 2'h1;
      end
    end
  end
endmodule // gfr_skid2

// [gfr_fifo_asserts.sv]
// port checks for the gesture buffer readout block
`timescale 1ns/1ps
module gfr_fifo_asserts
  import gfr_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic sda_oe_o,
  input wire logic irq_oe_o,
  input wire logic [GFR_LVL_W-1:0] fill_threshold_i,
  input wire logic gesture_irq_enable_i,
  input wire logic buffer_clear_bit_i,
  input wire logic prox_irq_set_i,
  input wire logic light_irq_set_i,
  input wire logic prox_irq_pending_o,
  input wire logic light_irq_pending_o,
  input wire logic gesture_interrupt_o,
  input wire logic [GFR_LVL_W-1:0] dataset_level_count_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  // any source except the forced one that must hold the interrupt pin low
  sequence irq_cause_s;
    prox_irq_pending_o || light_irq_pending_o || (gesture_interrupt_o && gesture_irq_enable_i);
  endsequence
  rst_idle_a: assert property ($rose(rst_n_i) |-> dataset_level_count_o == GFR_LVL_ZERO
    && !irq_oe_o && !sda_oe_o) else $error("not idle after reset");
  girq_cmp_a: assert property (gesture_interrupt_o ==
    (dataset_level_count_o > fill_threshold_i)) else $error("gesture interrupt wrong");
  lvl_max_a: assert property (dataset_level_count_o <= GFR_LVL_FULL)
    else $error("level above depth");
  lvl_step_a: assert property (!$past(buffer_clear_bit_i) |->
    dataset_level_count_o - $past(dataset_level_count_o) inside {8'h00, 8'h01, 8'hff})
    else $error("level jumped");
  clr_lvl_a: assert property (buffer_clear_bit_i |=> dataset_level_count_o == GFR_LVL_ZERO)
    else $error("clear left datasets");
  prox_set_a: assert property (prox_irq_set_i |=> prox_irq_pending_o)
    else $error("proximity event lost");
  light_set_a: assert property (light_irq_set_i |=> light_irq_pending_o)
    else $error("light event lost");
  irq_map_a: assert property (irq_cause_s |-> irq_oe_o)
    else $error("interrupt pin not driven");
endmodule // gfr_fifo_asserts

bind gfr_gesture_fifo_readout gfr_fifo_asserts u_chk (.clk_i, .rst_n_i, .sda_oe_o, .irq_oe_o,
  .fill_threshold_i, .gesture_irq_enable_i, .buffer_clear_bit_i, .prox_irq_set_i,
  .light_irq_set_i, .prox_irq_pending_o, .light_irq_pending_o, .gesture_interrupt_o,
  .dataset_level_count_o);

// [gfr_i2c_host.sv]
// serial bus controller model: register reads and address-only accesses
`timescale 1ns/1ps
module gfr_i2c_host
  import gfr_pkg::*;
(
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_low_o
);
  logic [7:0] rq[$];
  int nack = 0;
  // bus idles released, clock standing high between frames
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  // 160 ns bit; data moves only while the clock is low
  task automatic put(input logic b);
    #40 sda_low_o = !b;
    #40 scl_o = 1'b1;
    #80 scl_o = 1'b0;
  endtask
  task automatic get(output logic b);
    #40 sda_low_o = 1'b0;
    #40 scl_o = 1'b1;
    #40 b = sda_i;
    #40 scl_o = 1'b0;
  endtask
  // start and repeated start share one shape; 1 ns skew keeps off clock edges
  task automatic start();
    #41 sda_low_o = 1'b0;
    #40 scl_o = 1'b1;
    #40 sda_low_o = 1'b1;
    #40 scl_o = 1'b0;
  endtask
  task automatic stop();
    #40 sda_low_o = 1'b1;
    #40 scl_o = 1'b1;
    #40 sda_low_o = 1'b0;
  endtask
  task automatic wbyte(input logic [7:0] d);
    logic a;
    for (int i = 7; i >= 0; i--) put(d[i]);
    get(a);
    if (a) nack++;
  endtask
  // address-only write: target byte then register byte, no data
  task automatic touch(input logic [7:0] r);
    start();
    wbyte({GFR_DEF_BUS_ADDR, 1'b0});
    wbyte(r);
    stop();
  endtask
  // same access with a data byte after the register byte; the target ignores it
  task automatic touch_data(input logic [7:0] r, input logic [7:0] d);
    start();
    wbyte({GFR_DEF_BUS_ADDR, 1'b0});
    wbyte(r);
    wbyte(d);
    stop();
  endtask
  // pointer write, repeated start, n bytes with a nack on the last
  task automatic rd(input logic [7:0] r, input int n);
    logic [7:0] d;
    rq.delete();
    start();
    wbyte({GFR_DEF_BUS_ADDR, 1'b0});
    wbyte(r);
    start();
    wbyte({GFR_DEF_BUS_ADDR, 1'b1});
    for (int k = 0; k < n; k++) begin
      for (int i = 7; i >= 0; i--) get(d[i]);
      put(k == n - 1);
      rq.push_back(d);
    end
    stop();
  endtask
endmodule // gfr_i2c_host

// [gfr_gesture_fifo_readout_tb.sv]
// self-checking bench for the gesture buffer readout block
`timescale 1ns/1ps
module gfr_gesture_fifo_readout_tb;
  import gfr_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic vin = 1'b0;
  logic [31:0] din = 32'h0;
  logic [7:0] thr = 8'h01;
  logic act = 1'b1;
  logic gen = 1'b1;
  logic clr = 1'b0;
  logic ps = 1'b0;
  logic ls = 1'b0;
  logic scl, hl, sdo, soe, irq, rdy, pp, lp, girq;
  logic [7:0] lvl;
  // open drain with pull-up: low only where a side drives a zero
  wire sda = ~hl & ~(soe & ~sdo);
  logic [31:0] mq[$];
  logic ovf = 1'b0;
  logic vld = 1'b0;
  int n_fail = 0;
  int check_count = 0;
  int cyc = 0;
  gfr_gesture_fifo_readout DUT (.clk_i(clk), .rst_n_i(rst_n), .scl_i(scl), .sda_i(sda),
    .sda_o(sdo), .sda_oe_o(soe), .irq_oe_o(irq), .ds_valid_i(vin), .ds_data_i(din),
    .ds_ready_o(rdy), .fill_threshold_i(thr), .gesture_active_i(act),
    .gesture_irq_enable_i(gen), .buffer_clear_bit_i(clr), .prox_irq_set_i(ps),
    .light_irq_set_i(ls), .prox_irq_pending_o(pp), .light_irq_pending_o(lp),
    .gesture_interrupt_o(girq), .dataset_level_count_o(lvl));
  gfr_i2c_host host (.sda_i(sda), .scl_o(scl), .sda_low_o(hl));
  always #2.5 clk = ~clk;
  // hang guard, well above the bus traffic of all tests
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      n_fail++;
      end_of_test();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // valid flag model: setting wins over the idle clear
  task automatic upd();
    if (mq.size() > thr) vld = 1'b1;
    else if (!act && mq.size() == 0) vld = 1'b0;
  endtask
  // offer n random datasets; ready is looked at mid-cycle, where it is settled;
  // the next word is set at the accepting edge so no word is taken twice
  task automatic push(input int n);
    logic a;
    @(posedge clk);
    repeat (n) begin
      vin <= 1'b1;
      din <= $urandom;
      do begin
        @(negedge clk);
        a = rdy;
        @(posedge clk);
      end while (!a);
      if (mq.size() < 32) mq.push_back(din);
      else ovf = 1'b1;
    end
    vin <= 1'b0;
    repeat (6) @(posedge clk);
    upd();
  endtask
  // raise the buffer clear and leave it high for the caller to drop
  task automatic flush();
    @(posedge clk);
    clr <= 1'b1;
    repeat (3) @(posedge clk);
    mq.delete();
    ovf = 1'b0;
    vld = 1'b0;
  endtask
  // read n bytes from r and compare with the dataset queue model
  task automatic rdchk(input logic [7:0] r, input int n);
    logic [7:0] e;
    host.rd(r, n);
    foreach (host.rq[i]) begin
      if (r == GFR_LEVEL_ADDR) e = 8'(mq.size());
      else if (r == GFR_STATUS_ADDR) e = {6'h00, ovf, vld};
      else if (r < GFR_UP_ADDR || mq.size() == 0) e = 8'h00;
      else e = mq[0][8 * (r - GFR_UP_ADDR) +: 8];
      chk(host.rq[i], e);
      if (r == GFR_RIGHT_ADDR && mq.size() != 0) void'(mq.pop_front());
      r = (r == GFR_RIGHT_ADDR) ? GFR_UP_ADDR : r + 8'h01;
    end
    upd();
  endtask
  // main sequence
  initial begin
    void'($urandom(32'h6c7c));
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (8) @(negedge clk);
    chk(lvl, 8'h00);
    chk(8'(irq), 8'h00);
    rdchk(GFR_STATUS_ADDR, 1);
    $display("reset test done");
    push(3);
    @(negedge clk);
    chk(8'(girq), 8'h01);
    chk(8'(irq), 8'h01);
    rdchk(GFR_STATUS_ADDR, 1);
    rdchk(GFR_LEVEL_ADDR, 1);
    rdchk(GFR_UP_ADDR, 12);
    rdchk(GFR_UP_ADDR, 4);
    @(posedge clk);
    act <= 1'b0;
    repeat (3) @(posedge clk);
    upd();
    rdchk(GFR_STATUS_ADDR, 1);
    act <= 1'b1;
    $display("page read test done");
    push(1);
    for (int r = 0; r < 3; r++) rdchk(GFR_UP_ADDR + 8'(r), 1);
    chk(lvl, 8'h01);
    rdchk(GFR_RIGHT_ADDR, 1);
    @(negedge clk);
    chk(lvl, 8'h00);
    $display("single byte test done");
    thr <= 8'h00;
    push(2);
    fork
      rdchk(GFR_UP_ADDR, 8);
      begin
        repeat (2000) @(posedge clk);
        push(1);
      end
    join
    @(negedge clk);
    chk(8'(girq), 8'h01);
    $display("late arrival test done");
    flush();
    @(negedge clk);
    chk(lvl, 8'h00);
    chk(8'(girq), 8'h00);
    push(2);
    vin <= 1'b1;
    @(negedge clk);
    chk(8'(rdy), 8'h00);
    @(posedge clk);
    vin <= 1'b0;
    clr <= 1'b0;
    repeat (6) @(negedge clk);
    chk(lvl, 8'h02);
    rdchk(GFR_STATUS_ADDR, 1);
    $display("clear and stall test done");
    push(31);
    @(negedge clk);
    chk(lvl, GFR_LVL_FULL);
    rdchk(GFR_STATUS_ADDR, 1);
    rdchk(GFR_UP_ADDR, 4);
    flush();
    clr <= 1'b0;
    rdchk(GFR_STATUS_ADDR, 1);
    $display("overflow test done");
    push(1);
    gen <= 1'b0;
    @(negedge clk);
    chk(8'(irq), 8'h00);
    flush();
    clr <= 1'b0;
    gen <= 1'b1;
    // each clear access after both events are pending
    for (int k = 1; k < 4; k++) begin
      @(posedge clk);
      ps <= 1'b1;
      ls <= 1'b1;
      @(posedge clk);
      ps <= 1'b0;
      ls <= 1'b0;
      host.touch(GFR_FORCE_ADDR + 8'(k));
      @(negedge clk);
      chk({5'h00, pp, lp, irq}, {5'h00, k == 2, k == 1, k != 3});
    end
    host.touch(GFR_FORCE_ADDR);
    @(negedge clk);
    chk(8'(irq), 8'h01);
    host.touch(GFR_NONGEST_CLR_ADDR);
    @(negedge clk);
    chk(8'(irq), 8'h00);
    host.touch_data(GFR_FORCE_ADDR, 8'($urandom));
    @(negedge clk);
    chk(8'(irq), 8'h01);
    chk(8'(host.nack), 8'h00);
    $display("interrupt test done");
    end_of_test();
  end
endmodule // gfr_gesture_fifo_readout_tb
